// ### src/tgc_pkg.sv
// Package of constants, register map and types for the gated 16-bit timer/counter
package tgc_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [5:0] IDX_INTERRUPT_CONTROL = 6'h0b;
  localparam logic [5:0] IDX_PERIPHERAL_FLAGS = 6'h0c;
  localparam logic [5:0] IDX_COUNT_LOW_BYTE = 6'h0e;
  localparam logic [5:0] IDX_COUNT_HIGH_BYTE = 6'h0f;
  localparam logic [5:0] IDX_TIMER_CONTROL = 6'h10;
  localparam logic [5:0] IDX_PERIPHERAL_ENABLE = 6'h11;

  // ==========================================================================
  // Field positions
  localparam int BIT_GLOBAL_IRQ_ENABLE = 7;
  localparam int BIT_PERIPHERAL_IRQ_ENABLE = 6;
  localparam int BIT_ROLLOVER_FLAG = 0;
  localparam int BIT_ROLLOVER_ENABLE = 0;

  // ==========================================================================
  // Values after reset and fixed counts
  localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;
  localparam logic [7:0] RST_PERIPHERAL_ENABLE = 8'h00;
  localparam logic [7:0] RST_TIMER_CONTROL = 8'h00;
  localparam logic [7:0] TIMER_CONTROL_WMASK = 8'h7f;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] COUNT_STEP = 16'h0001;
  localparam int PRESCALE_W = 3;
  localparam int PIN_COUNT = 3;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic reserved;
    logic gate_enable;
    logic [1:0] prescale_select;
    logic crystal_osc_enable;
    logic sync_bypass;
    logic clock_source_select;
    logic timer_run;
  } tgc_ctrl_t;

  typedef enum logic [1:0] {
    TGC_ARM_WAIT = 2'b01,
    TGC_ARM_READY = 2'b10
  } tgc_arm_t;

endpackage : tgc_pkg

// ### src/tgc_prescaler.sv
// Prescale counter dividing the count clock by 1, 2, 4 or 8
`timescale 1ns/10ps
`default_nettype none
module tgc_prescaler
  import tgc_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic clear_in,
  input wire logic tick_in,
  input wire logic [1:0] select_in,
  output logic tick_out,
  output logic [PRESCALE_W-1:0] count_out
);

  // ==========================================================================
  // Divider
  logic [PRESCALE_W-1:0] count;

  // Mask of low bits that must all be one before a tick passes
  function automatic logic [PRESCALE_W-1:0] div_mask(input logic [1:0] sel);
    logic [PRESCALE_W:0] one_hot;
    one_hot = (PRESCALE_W+1)'(1) << sel;
    div_mask = PRESCALE_W'(one_hot - (PRESCALE_W+1)'(1));
  endfunction : div_mask

  // Ratio set by the select field [R13]
  assign tick_out = tick_in && ((count & div_mask(select_in)) == div_mask(select_in));
  assign count_out = count;

  // A count byte write empties the divider and beats a tick in the same cycle
  always_ff @(posedge clk_sys_in) begin
    if (rst_in || clear_in) begin // [R14]
      count <= '0;
    end else if (tick_in) begin
      count <= count + PRESCALE_W'(1);
    end
  end

endmodule : tgc_prescaler
`default_nettype wire

// ### src/tgc_timer.sv
// Gated 16-bit timer/counter with prescaler, rollover flag and Wishbone registers
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// (R1) Three modes exist: timer with prescaler, synchronised counter and unsynchronised counter.
// (R2) In timer mode the count steps once per system clock cycle after the prescaler.
// (R3) In counter mode the count steps on rising edges of the external count pin after prescaling.
// (R4) In counter mode the external clock is either resynchronised or used directly.
// (R5) With gating enabled, counting stops while the active-low gate pin is high.
// (R6) The low-power crystal input may replace the count pin as the external clock.
// (R7) A falling edge of the external clock must be seen before the first counted rising edge.
// (R8) The count runs up to ffff and wraps to 0000 on the next step.
// (R9) Each wrap sets the rollover flag at bit 0 of the peripheral flag register.
// (R10) The interrupt rises only when rollover, its enable, peripheral and global enables are set.
// (R11) The rollover flag stays set until software writes it clear.
// (R12) Software should clear both count bytes and the flag before enabling interrupts.
// (R13) A two-bit select at bits 5:4 of timer control divides by 1, 2, 4 or 8.
// (R14) The prescale counter is hidden and is cleared by any write to either count byte.
// (R15) Run bit enables counting, source bit picks the external clock, bypass bit skips resync.
module tgc_timer
  import tgc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [ADDR_W-1:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic ext_count_clock_pin_in,
  input wire logic count_gate_pin_n_in,
  input wire logic low_power_crystal_osc_in,
  output logic irq_out
);

  // ==========================================================================
  // Register bus
  logic req;
  logic wr_strobe;
  logic [7:0] wr_byte;
  logic [31:0] next_rdata;

  // Register index hit, used by every decode below
  function automatic logic reg_hit(input logic [ADDR_W-1:0] adr, input logic [5:0] idx);
    reg_hit = (adr[ADDR_W-1:2] == (ADDR_W-2)'(idx));
  endfunction : reg_hit

  assign req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign wr_strobe = req && wb_we_in && wb_sel_in[0];
  assign wr_byte = wb_dat_in[7:0];

  // Every request is acked one cycle after it appears, mapped or not
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      wb_ack_out <= 1'b0;
    end else begin
      wb_ack_out <= req;
    end
  end

  // ==========================================================================
  // Software-visible registers
  tgc_ctrl_t ctrl;
  logic [7:0] interrupt_control;
  logic [7:0] peripheral_enable_reg;
  logic rollover_flag;
  logic [15:0] count;
  logic wr_ctrl;
  logic wr_intc;
  logic wr_pen;
  logic wr_flags;
  logic wr_lo;
  logic wr_hi;

  assign wr_ctrl = wr_strobe && reg_hit(wb_adr_in, IDX_TIMER_CONTROL);
  assign wr_intc = wr_strobe && reg_hit(wb_adr_in, IDX_INTERRUPT_CONTROL);
  assign wr_pen = wr_strobe && reg_hit(wb_adr_in, IDX_PERIPHERAL_ENABLE);
  assign wr_flags = wr_strobe && reg_hit(wb_adr_in, IDX_PERIPHERAL_FLAGS);
  assign wr_lo = wr_strobe && reg_hit(wb_adr_in, IDX_COUNT_LOW_BYTE);
  assign wr_hi = wr_strobe && reg_hit(wb_adr_in, IDX_COUNT_HIGH_BYTE);

  // Control bits; top bit is unimplemented and reads zero
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ctrl <= tgc_ctrl_t'(RST_TIMER_CONTROL);
    end else if (wr_ctrl) begin
      ctrl <= tgc_ctrl_t'(wr_byte & TIMER_CONTROL_WMASK); // [R15]
    end
  end

  // Enable registers are plain storage
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      interrupt_control <= RST_INTERRUPT_CONTROL;
      peripheral_enable_reg <= RST_PERIPHERAL_ENABLE;
    end else begin
      if (wr_intc) begin
        interrupt_control <= wr_byte;
      end
      if (wr_pen) begin
        peripheral_enable_reg <= wr_byte;
      end
    end
  end

  // Read data is captured with the request so it is stable under ack
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (reg_hit(wb_adr_in, IDX_TIMER_CONTROL)) begin
      next_rdata[7:0] = ctrl;
    end else if (reg_hit(wb_adr_in, IDX_INTERRUPT_CONTROL)) begin
      next_rdata[7:0] = interrupt_control;
    end else if (reg_hit(wb_adr_in, IDX_PERIPHERAL_ENABLE)) begin
      next_rdata[7:0] = peripheral_enable_reg;
    end else if (reg_hit(wb_adr_in, IDX_PERIPHERAL_FLAGS)) begin
      next_rdata[BIT_ROLLOVER_FLAG] = rollover_flag;
    end else if (reg_hit(wb_adr_in, IDX_COUNT_LOW_BYTE)) begin
      next_rdata[7:0] = count[7:0];
    end else if (reg_hit(wb_adr_in, IDX_COUNT_HIGH_BYTE)) begin
      next_rdata[7:0] = count[15:8];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      wb_dat_out <= 32'h0000_0000;
    end else if (req) begin
      wb_dat_out <= next_rdata;
    end
  end

  // ==========================================================================
  // Pin synchronisers: count pin, gate pin, crystal input
  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] pin_meta;
  logic [PIN_COUNT-1:0] pin_sync;

  assign pin_raw = {low_power_crystal_osc_in, count_gate_pin_n_in, ext_count_clock_pin_in};

  // Only the second stage is ever looked at
  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_sync
    always_ff @(posedge clk_sys_in) begin
      if (rst_in) begin
        pin_meta[i] <= 1'b0;
        pin_sync[i] <= 1'b0;
      end else begin
        pin_meta[i] <= pin_raw[i];
        pin_sync[i] <= pin_meta[i];
      end
    end
  end

  // ==========================================================================
  // External clock edge detection and arming
  logic ext_level;
  logic ext_prev;
  logic ext_rise;
  logic ext_fall;
  logic [PIN_COUNT-1:0] pin_prev;
  tgc_arm_t arm_state;

  // Crystal replaces the count pin when its enable is set; each line keeps its own
  // history, so flipping the source select never fakes an edge that would arm the count
  assign ext_level = ctrl.crystal_osc_enable ? pin_sync[2] : pin_sync[0]; // [R6]
  assign ext_prev = ctrl.crystal_osc_enable ? pin_prev[2] : pin_prev[0];
  assign ext_rise = ext_level && !ext_prev;
  assign ext_fall = !ext_level && ext_prev;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pin_prev <= '0;
    end else begin
      pin_prev <= pin_sync;
    end
  end

  // A pin already high at enable must fall before any rise counts
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      arm_state <= TGC_ARM_WAIT;
    end else begin
      case (arm_state)
        TGC_ARM_WAIT: begin
          if (ctrl.timer_run && ctrl.clock_source_select && ext_fall) begin
            arm_state <= TGC_ARM_READY; // [R7]
          end
        end
        TGC_ARM_READY: begin
          if (!ctrl.timer_run || !ctrl.clock_source_select) begin
            arm_state <= TGC_ARM_WAIT;
          end
        end
        default: begin
          arm_state <= TGC_ARM_WAIT;
        end
      endcase
    end
  end

  // ==========================================================================
  // Tick path: gate, source, prescaler, optional resync stage
  logic gate_open;
  logic src_tick;
  logic pre_tick;
  logic sync_tick;
  logic inc;
  logic count_wr;
  logic [PRESCALE_W-1:0] pre_count;

  assign gate_open = !ctrl.gate_enable || !pin_sync[1]; // [R5]
  assign src_tick = ctrl.timer_run && gate_open && // [R15]
    (ctrl.clock_source_select ? (arm_state == TGC_ARM_READY) && ext_rise : 1'b1); // [R2] [R3]
  assign count_wr = wr_lo || wr_hi;

  tgc_prescaler u_prescaler (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .clear_in(count_wr), // [R14]
    .tick_in(src_tick),
    .select_in(ctrl.prescale_select), // [R13]
    .tick_out(pre_tick),
    .count_out(pre_count)
  );

  // Resync stage costs one cycle of latency; bypass trades that for raw edge timing
  always_ff @(posedge clk_sys_in) begin
    if (rst_in || count_wr) begin
      sync_tick <= 1'b0;
    end else begin
      sync_tick <= pre_tick;
    end
  end

  assign inc = (ctrl.clock_source_select && !ctrl.sync_bypass) ? sync_tick : pre_tick; // [R1] [R4]

  // ==========================================================================
  // Count, rollover flag and interrupt
  logic [15:0] next_count;
  logic rollover;

  assign rollover = inc && (count == COUNT_MAX);

  // A byte write overrides its own byte of a step landing in the same cycle; the other byte still steps
  always_comb begin
    next_count = count;
    if (inc) begin
      next_count = count + COUNT_STEP; // [R8]
    end
    if (wr_lo) begin
      next_count[7:0] = wr_byte;
    end
    if (wr_hi) begin
      next_count[15:8] = wr_byte;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      count <= RST_COUNT;
    end else begin
      count <= next_count;
    end
  end

  // Hardware set beats a software clear in the same cycle
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      rollover_flag <= 1'b0;
    end else if (rollover) begin
      rollover_flag <= 1'b1; // [R9]
    end else if (wr_flags) begin
      rollover_flag <= wr_byte[BIT_ROLLOVER_FLAG]; // [R11]
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= rollover_flag && peripheral_enable_reg[BIT_ROLLOVER_ENABLE] && // [R10]
        interrupt_control[BIT_PERIPHERAL_IRQ_ENABLE] &&
        interrupt_control[BIT_GLOBAL_IRQ_ENABLE];
    end
  end

  // ==========================================================================
  // Checks
  a_wrap_sets_flag: assert property ( // [R8] [R9]
    @(posedge clk_sys_in) disable iff (rst_in)
    (rollover && !count_wr) |=> (count == 16'h0000) && rollover_flag)
    else $error("wrap did not zero count and set flag");
  a_flag_sticks: assert property ( // [R11]
    @(posedge clk_sys_in) disable iff (rst_in)
    (rollover_flag && !wr_flags) |=> rollover_flag)
    else $error("rollover flag dropped without a clear");
  a_irq_needs_all: assert property ( // [R10]
    @(posedge clk_sys_in) disable iff (rst_in)
    irq_out |-> $past(rollover_flag) && $past(interrupt_control[7]) &&
      $past(interrupt_control[6]) && $past(peripheral_enable_reg[0]))
    else $error("interrupt raised without all enables");
  a_timer_steps: assert property ( // [R2]
    @(posedge clk_sys_in) disable iff (rst_in)
    (ctrl.timer_run && !ctrl.clock_source_select && !ctrl.gate_enable &&
      ctrl.prescale_select == 2'b00 && !count_wr) |=> count == $past(count) + 16'h0001)
    else $error("timer mode missed a step");
  a_stopped_holds: assert property ( // [R15]
    @(posedge clk_sys_in) disable iff (rst_in)
    (!ctrl.timer_run && !sync_tick && !count_wr) |=> $stable(count))
    else $error("count moved while stopped");
  a_gate_blocks: assert property ( // [R5]
    @(posedge clk_sys_in) disable iff (rst_in)
    (ctrl.gate_enable && pin_sync[1] && !ctrl.clock_source_select && !count_wr)
      |=> $stable(count))
    else $error("count moved with gate closed");
  a_write_clears_pre: assert property ( // [R14]
    @(posedge clk_sys_in) disable iff (rst_in)
    count_wr |=> pre_count == 3'h0)
    else $error("prescaler not cleared by count write");
  a_unarmed_holds: assert property ( // [R7]
    @(posedge clk_sys_in) disable iff (rst_in)
    (arm_state == TGC_ARM_WAIT && ctrl.clock_source_select && ctrl.sync_bypass && !count_wr)
      |=> $stable(count))
    else $error("counted before a falling edge");
  a_divide_by_two: assert property ( // [R13]
    @(posedge clk_sys_in) disable iff (rst_in)
    (ctrl.timer_run && !ctrl.clock_source_select && !ctrl.gate_enable &&
      ctrl.prescale_select == 2'b01 && inc && !count_wr) ##1 !count_wr |=> !$past(inc))
    else $error("divide by two stepped twice in a row");
  a_ack_pulse: assert property (
    @(posedge clk_sys_in) disable iff (rst_in)
    req |=> wb_ack_out ##1 !wb_ack_out)
    else $error("ack not a single cycle after request");

endmodule : tgc_timer
`default_nettype wire

// ### tb/tgc_ext_source.sv
// External count clock source and low-power crystal model for the timer bench
`timescale 1ns/10ps
`default_nettype none
module tgc_ext_source #(
  parameter int HALF_NS = 370
) (
  output logic pin_out,
  output logic xtal_out
);
  // ==========================================================================
  // Idle level
  // Both clocks rest high, so every train opens with a falling edge
  initial begin
    pin_out = 1'b1;
    xtal_out = 1'b1;
  end

  // ==========================================================================
  // Drivers
  // Drive one level on the chosen line
  task automatic level(input logic xt, input logic v);
    if (xt) begin
      xtal_out = v;
    end else begin
      pin_out = v;
    end
  endtask : level

  // Falling edge first, then a rise; half periods outlast the pin synchroniser
  task automatic train(input int n, input logic xt);
    for (int i = 0; i < n; i++) begin
      level(xt, 1'b0);
      #HALF_NS;
      level(xt, 1'b1);
      #HALF_NS;
    end
  endtask : train
endmodule : tgc_ext_source
`default_nettype wire

// ### tb/sixteen_bit_gated_timer_counter_tb.sv
// Self-checking bench for the gated 16-bit timer/counter
`timescale 1ns/10ps
`default_nettype none
module sixteen_bit_gated_timer_counter_tb;
  import tgc_pkg::*;
  logic clk, rst, cyc, stb, we, gate_n, irq, ack;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, rd;
  wire logic pin, xtal;
  int n_errors, check_count, cycles;

  // ==========================================================================
  // Design and far-side model
  tgc_timer i_dut (
    .clk_sys_in(clk), .rst_in(rst), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .ext_count_clock_pin_in(pin),
    .count_gate_pin_n_in(gate_n), .low_power_crystal_osc_in(xtal), .irq_out(irq)
  );
  tgc_ext_source i_src (.pin_out(pin), .xtal_out(xtal));

  // ==========================================================================
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Whole run needs about 1000 cycles; the ceiling leaves a wide margin
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      end_of_test();
    end
  end

  // ==========================================================================
  // Bus and compare tasks
  // Classic cycle: hold everything until the rising edge that samples ack high,
  // take read data at that edge, and only then release the request
  task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h000000, d};
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    wb(1'b1, idx, d);
  endtask : wr
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val
  task automatic check_rng(input logic [31:0] got, input int lo, input int hi);
    check_count++;
    if ($isunknown(got) || got < lo || got > hi) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %h outside %0d..%0d", $time, got, lo, hi);
    end
  endtask : check_rng
  task automatic rdchk(input logic [5:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    check_val(rd, {24'h000000, exp});
  endtask : rdchk
  // Stop the timer, clear both count bytes (also the prescaler) and the rollover flag
  task automatic clr();
    wr(IDX_TIMER_CONTROL, 8'h00);
    wr(IDX_COUNT_LOW_BYTE, 8'h00);
    wr(IDX_COUNT_HIGH_BYTE, 8'h00);
    wr(IDX_PERIPHERAL_FLAGS, 8'h00);
  endtask : clr

  // ==========================================================================
  // Scenarios
  task automatic test_reset();
    rdchk(IDX_INTERRUPT_CONTROL, RST_INTERRUPT_CONTROL);
    rdchk(IDX_PERIPHERAL_FLAGS, 8'h00);
    rdchk(IDX_COUNT_LOW_BYTE, RST_COUNT[7:0]);
    rdchk(IDX_COUNT_HIGH_BYTE, RST_COUNT[15:8]);
    rdchk(IDX_TIMER_CONTROL, RST_TIMER_CONTROL);
    rdchk(IDX_PERIPHERAL_ENABLE, RST_PERIPHERAL_ENABLE);
    wr(6'h0d, 8'hff);
    rdchk(6'h0d, 8'h00);
    wr(IDX_TIMER_CONTROL, 8'h80);
    rdchk(IDX_TIMER_CONTROL, 8'h00);
    // A write without the low byte lane must leave the register untouched
    sel <= 4'he;
    wr(IDX_TIMER_CONTROL, 8'h01);
    sel <= 4'hf;
    rdchk(IDX_TIMER_CONTROL, 8'h00);
    $display("test reset done");
  endtask : test_reset

  task automatic test_timer_prescale();
    for (int ps = 0; ps < 4; ps++) begin
      clr();
      wr(IDX_TIMER_CONTROL, {2'b00, ps[1:0], 4'h1});
      repeat (64) @(posedge clk);
      wr(IDX_TIMER_CONTROL, 8'h00);
      wb(1'b0, IDX_COUNT_LOW_BYTE, 8'h00);
      check_rng(rd, 64 >> ps, (72 >> ps) + 1);
    end
    $display("test timer prescale done");
  endtask : test_timer_prescale

  task automatic test_gate();
    clr();
    gate_n <= 1'b1;
    wr(IDX_TIMER_CONTROL, 8'h41);
    repeat (40) @(posedge clk);
    rdchk(IDX_COUNT_LOW_BYTE, 8'h00);
    gate_n <= 1'b0;
    repeat (40) @(posedge clk);
    wr(IDX_TIMER_CONTROL, 8'h00);
    wb(1'b0, IDX_COUNT_LOW_BYTE, 8'h00);
    check_rng(rd, 30, 50);
    $display("test gate done");
  endtask : test_gate

  // High-byte writes every 3 cycles keep a divide-by-8 prescaler from firing
  task automatic test_prescale_clear();
    clr();
    wr(IDX_TIMER_CONTROL, 8'h31);
    for (int i = 0; i < 12; i++) begin
      wr(IDX_COUNT_HIGH_BYTE, 8'h00);
    end
    wr(IDX_TIMER_CONTROL, 8'h00);
    rdchk(IDX_COUNT_LOW_BYTE, 8'h00);
    $display("test prescale clear done");
  endtask : test_prescale_clear

  // A rise with no falling edge since run must not count
  task automatic test_counter(input logic [7:0] c, input int n, input logic xt,
                              input logic [7:0] exp);
    clr();
    i_src.level(xt, 1'b0);
    repeat (6) @(posedge clk);
    wr(IDX_TIMER_CONTROL, c);
    i_src.level(xt, 1'b1);
    repeat (10) @(posedge clk);
    i_src.train(n, xt);
    repeat (10) @(posedge clk);
    rdchk(IDX_COUNT_LOW_BYTE, exp);
    $display("test counter %h done", c);
  endtask : test_counter

  task automatic test_rollover();
    clr();
    wr(IDX_COUNT_HIGH_BYTE, 8'hff);
    wr(IDX_COUNT_LOW_BYTE, 8'hfe);
    wr(IDX_TIMER_CONTROL, 8'h01);
    repeat (10) @(posedge clk);
    wr(IDX_TIMER_CONTROL, 8'h00);
    rdchk(IDX_COUNT_HIGH_BYTE, 8'h00);
    wb(1'b0, IDX_COUNT_LOW_BYTE, 8'h00);
    check_rng(rd, 8, 14);
    repeat (20) @(posedge clk);
    rdchk(IDX_PERIPHERAL_FLAGS, 8'h01);
    for (int k = 0; k < 8; k++) begin
      wr(IDX_PERIPHERAL_ENABLE, {7'h00, k[0]});
      wr(IDX_INTERRUPT_CONTROL, {k[2], k[1], 6'h00});
      repeat (2) @(negedge clk);
      check_val({31'h0, irq}, {31'h0, k == 7});
    end
    wr(IDX_PERIPHERAL_FLAGS, 8'h00);
    repeat (2) @(negedge clk);
    check_val({31'h0, irq}, 32'h0);
    rdchk(IDX_PERIPHERAL_FLAGS, 8'h00);
    wr(IDX_INTERRUPT_CONTROL, 8'h00);
    $display("test rollover done");
  endtask : test_rollover

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  // ==========================================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    {cyc, stb, we, gate_n} = 4'h0;
    adr = 8'h00;
    sel = 4'hf;
    wdat = 32'h0;
    {n_errors, check_count, cycles} = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    test_reset();
    test_timer_prescale();
    test_gate();
    test_prescale_clear();
    test_counter(8'h03, 5, 1'b0, 8'h05);
    test_counter(8'h17, 6, 1'b0, 8'h03);
    test_counter(8'h0f, 4, 1'b1, 8'h04);
    test_counter(8'h2b, 8, 1'b1, 8'h02);
    test_rollover();
    end_of_test();
  end
endmodule : sixteen_bit_gated_timer_counter_tb
`default_nettype wire
